// >>> tb/asw_monitor.sv
`timescale 1ns/10ps
// Purpose: Pin protocol checks on the memory controller.
// Assumes: One clock domain.
// Notes: Bound from the bench.
module asw_monitor
  import asw_pkg::*;
(
  // Clock and reset
  input wire logic              mclk,
  input wire logic              rst_b,
  // Sleep flag and memory pins
  input wire logic              asleep,
  input wire logic [ADDR_W-1:0] word_address,
  input wire logic              primary_select_n,
  input wire logic              secondary_select,
  input wire logic              write_strobe_n,
  input wire logic              output_drive_n,
  input wire logic              low_lane_select_n,
  input wire logic              high_lane_select_n,
  input wire logic [DATA_W-1:0] data_pins_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic sel;
  assign sel = !primary_select_n && secondary_select;
  sequence s_wr_start;
    $fell(write_strobe_n);
  endsequence
  sequence s_wr_hold;
    !write_strobe_n [*7];
  endsequence
  no_contend_a: assert property (sel && !output_drive_n |-> data_pins_oe == '0)
    else $error("bus driven during read");
  drive_off_a: assert property (|data_pins_oe |-> output_drive_n)
    else $error("bus driven with output on");
  wr_pulse_a: assert property (s_wr_start |-> s_wr_hold)
    else $error("write pulse short");
  wr_overlap_a: assert property (!write_strobe_n |-> sel && !(low_lane_select_n && high_lane_select_n))
    else $error("write outside selection");
  rd_window_a: assert property ($fell(output_drive_n) |-> (sel && write_strobe_n) [*8])
    else $error("read window short");
  addr_hold_a: assert property (sel && $past(sel) |-> $stable(word_address))
    else $error("address moved in access");
  low_lane_a: assert property (|data_pins_oe[7:0] |-> !low_lane_select_n || $past(!low_lane_select_n))
    else $error("low byte driven unselected");
  high_lane_a: assert property (|data_pins_oe[15:8] |-> !high_lane_select_n || $past(!high_lane_select_n))
    else $error("high byte driven unselected");
  sleep_idle_a: assert property (asleep |-> !sel || (low_lane_select_n && high_lane_select_n))
    else $error("access while asleep");
endmodule // asw_monitor

// >>> tb/asw_sram_model.sv
`timescale 1ns/10ps
// Purpose: Behavioural static memory facing the controller.
// Assumes: Writes commit when the write overlap ends.
// Notes: Undriven lanes show the inverse word, never a stale match.
module asw_sram_model
  import asw_pkg::*;
(
  // Controls
  input wire logic [ADDR_W-1:0] word_address,
  input wire logic              primary_select_n,
  input wire logic              secondary_select,
  input wire logic              write_strobe_n,
  input wire logic              output_drive_n,
  input wire logic              low_lane_select_n,
  input wire logic              high_lane_select_n,
  // Data
  input wire logic [DATA_W-1:0] data_pins_out,
  input wire logic [DATA_W-1:0] data_pins_oe,
  output logic     [DATA_W-1:0] data_bus
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic              sel, wr, rd;
  logic              cap_lo = 1'b0;
  logic              cap_hi = 1'b0;
  logic [ADDR_W-1:0] cap_a;
  logic [DATA_W-1:0] dout, drv, cap_d;
  assign sel = !primary_select_n && secondary_select;
  assign wr = sel && !write_strobe_n && !(low_lane_select_n && high_lane_select_n);
  assign rd = sel && write_strobe_n && !output_drive_n;
  assign drv = {{8{rd && !high_lane_select_n}}, {8{rd && !low_lane_select_n}}};
  assign dout = mem[word_address];
  // Both parties driving any one bit shows the whole bus as unknown
  assign data_bus = |(data_pins_oe & drv) ? 'x : (data_pins_oe & data_pins_out) | (~data_pins_oe & ~(dout ^ drv));
  // Lanes gathered over the whole overlap, so pin settling order cannot drop one
  always @* begin
    if (wr) begin
      cap_a = word_address;
      cap_lo = cap_lo | !low_lane_select_n;
      cap_hi = cap_hi | !high_lane_select_n;
      cap_d = data_bus;
    end
  end
  always @(negedge wr) begin
    if (cap_lo === 1'b1) mem[cap_a][7:0] = cap_d[7:0];
    if (cap_hi === 1'b1) mem[cap_a][15:8] = cap_d[15:8];
    cap_lo = 1'b0;
    cap_hi = 1'b0;
  end
endmodule // asw_sram_model

// >>> tb/async_sram_word_byte_access_test.sv
`timescale 1ns/10ps
// Purpose: Self-checking bench for the memory controller.
// Assumes: Recovery shortened to RCV cycles.
// Notes: Inputs change on the falling edge.
module async_sram_word_byte_access_test
  import asw_pkg::*;
;
  localparam int RCV = 20;
  logic              mclk = 0, rst_b = 0, req_valid = 0;
  asw_op_t           req_op = ASW_OP_READ;
  asw_ret_t          req_ret = ASW_RET_SEC;
  logic [ADDR_W-1:0] req_addr = '0, word_address;
  logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, data_pins_in, data_pins_out, data_pins_oe;
  logic [1:0]        req_lanes = '0;
  logic              req_ready, rsp_valid, asleep, primary_select_n, secondary_select;
  logic              write_strobe_n, output_drive_n, low_lane_select_n, high_lane_select_n;
  int                fails = 0, n_compared = 0, cyc = 0, lat;
  always #2.5 mclk = ~mclk;
  asw_ctrl #(.RECOVER_CYC(RCV)) i_dut (.mclk, .rst_b, .req_valid, .req_ready, .req_op, .req_ret, .req_addr,
    .req_wdata, .req_lanes, .rsp_valid, .rsp_rdata, .asleep, .word_address, .primary_select_n,
    .secondary_select, .write_strobe_n, .output_drive_n, .low_lane_select_n, .high_lane_select_n,
    .data_pins_in, .data_pins_out, .data_pins_oe);
  asw_sram_model i_mem (.word_address, .primary_select_n, .secondary_select, .write_strobe_n,
    .output_drive_n, .low_lane_select_n, .high_lane_select_n, .data_pins_out, .data_pins_oe,
    .data_bus(data_pins_in));
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      $display("[ERR] %0t run hung", $time);
      end_sim();
    end
  end
  task automatic chk16(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic req(input asw_op_t op, input asw_ret_t r, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic [1:0] ln);
    int n;
    n = 0;
    // One edge always passes so valid is never lowered and raised in one step
    do begin
      @(negedge mclk);
      n++;
    end while (req_ready !== 1'b1 && n < 100);
    req_op = op;
    req_ret = r;
    req_addr = a;
    req_wdata = d;
    req_lanes = ln;
    req_valid = 1;
    @(negedge mclk);
    req_valid = 0;
    lat = 1;
    while (rsp_valid !== 1'b1 && lat < 200) begin
      @(negedge mclk);
      lat++;
    end
    chk16(16'(rsp_valid), 16'h0001, "no answer");
  endtask
  task automatic t_word();
    req(ASW_OP_WRITE, ASW_RET_SEC, 18'h3_ffff, 16'h1234, 2'b11);
    req(ASW_OP_WRITE, ASW_RET_SEC, 18'h0_0000, 16'hedcb, 2'b11);
    req(ASW_OP_READ, ASW_RET_SEC, 18'h3_ffff, 16'h0000, 2'b11);
    chk16(rsp_rdata, 16'h1234, "word read");
  endtask
  task automatic t_bytes();
    req(ASW_OP_WRITE, ASW_RET_SEC, 18'h3_ffff, 16'haa55, 2'b01);
    req(ASW_OP_READ, ASW_RET_SEC, 18'h3_ffff, 16'h0000, 2'b11);
    chk16(rsp_rdata, 16'h1255, "low write");
    req(ASW_OP_WRITE, ASW_RET_SEC, 18'h3_ffff, 16'h66bb, 2'b10);
    req(ASW_OP_READ, ASW_RET_SEC, 18'h3_ffff, 16'h0000, 2'b11);
    chk16(rsp_rdata, 16'h6655, "high write");
    req(ASW_OP_READ, ASW_RET_SEC, 18'h3_ffff, 16'h0000, 2'b01);
    chk16(rsp_rdata, 16'h0055, "low read");
    req(ASW_OP_READ, ASW_RET_SEC, 18'h3_ffff, 16'h0000, 2'b10);
    chk16(rsp_rdata, 16'h6600, "high read");
  endtask
  task automatic t_none();
    req(ASW_OP_WRITE, ASW_RET_SEC, 18'h3_ffff, 16'h0000, 2'b00);
    req(ASW_OP_READ, ASW_RET_SEC, 18'h3_ffff, 16'h0000, 2'b11);
    chk16(rsp_rdata, 16'h6655, "no lane write");
    req(ASW_OP_READ, ASW_RET_SEC, 18'h0_0000, 16'h0000, 2'b11);
    chk16(rsp_rdata, 16'hedcb, "other word");
  endtask
  task automatic t_sleep(input asw_ret_t r, input logic [DATA_W-1:0] d);
    req(ASW_OP_WRITE, ASW_RET_SEC, 18'h1_2345, d, 2'b11);
    req(ASW_OP_SLEEP, r, 18'h0_0000, 16'h0000, 2'b00);
    chk16(16'(asleep), 16'h0001, "asleep");
    if (r == ASW_RET_SEC) begin
      chk16(16'(secondary_select), 16'h0000, "sec style");
    end else if (r == ASW_RET_PRI) begin
      chk16(16'({primary_select_n, secondary_select}), 16'h0003, "pri style");
    end else begin
      chk16(16'({primary_select_n, low_lane_select_n, high_lane_select_n}), 16'h0003, "lane style");
    end
    // A write while asleep must be dropped
    req(ASW_OP_WRITE, r, 18'h1_2345, ~d, 2'b11);
    req(ASW_OP_WAKE, r, 18'h0_0000, 16'h0000, 2'b00);
    chk16(16'(lat >= RCV), 16'h0001, "recovery wait");
    chk16(16'(asleep), 16'h0000, "awake");
    req(ASW_OP_READ, ASW_RET_SEC, 18'h1_2345, 16'h0000, 2'b11);
    chk16(rsp_rdata, d, "retained");
  endtask
  initial begin
    repeat (12) @(negedge mclk);
    rst_b = 1;
    t_word();
    t_bytes();
    t_none();
    t_sleep(ASW_RET_SEC, 16'h5a5a);
    t_sleep(ASW_RET_PRI, 16'ha5a5);
    t_sleep(ASW_RET_LANE, 16'h0ff0);
    end_sim();
  end
endmodule // async_sram_word_byte_access_test
bind asw_ctrl asw_monitor i_mon (.mclk, .rst_b, .asleep, .word_address, .primary_select_n, .secondary_select,
  .write_strobe_n, .output_drive_n, .low_lane_select_n, .high_lane_select_n, .data_pins_oe);

// >>> verilog/asw_ctrl.sv
`timescale 1ns/10ps
// Purpose: Host controller driving an asynchronous 256K x 16 static memory through its pins.
// Assumes: Pins face the memory directly; data_pins_in comes from the pad and is synchronised.
// Notes: One request at a time; retention and wake are explicit operations.
module asw_ctrl
  import asw_pkg::*;
#(
  parameter int RECOVER_CYC = RCV_CYC
)
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_b,
  // User request
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire asw_op_t           req_op,
  input  wire asw_ret_t          req_ret,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic [1:0]        req_lanes,
  // User answer
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  output logic                   asleep,
  // Memory pins
  output logic [ADDR_W-1:0]      word_address,
  output logic                   primary_select_n,
  output logic                   secondary_select,
  output logic                   write_strobe_n,
  output logic                   output_drive_n,
  output logic                   low_lane_select_n,
  output logic                   high_lane_select_n,
  input  wire logic [DATA_W-1:0] data_pins_in,
  output logic [DATA_W-1:0]      data_pins_out,
  output logic [DATA_W-1:0]      data_pins_oe
);
  if (RECOVER_CYC < 1) begin : g_bad_recover
    $error("RECOVER_CYC must be at least one");
  end

  typedef enum logic [2:0] {
    ASW_S_IDLE,
    ASW_S_RD,
    ASW_S_RD_HZ,
    ASW_S_WR,
    ASW_S_WR_END,
    ASW_S_SLEEP,
    ASW_S_WAKE
  } asw_state_t;

  asw_tmr_if tmr ();
  asw_timer u_timer (
    .mclk  (mclk),
    .rst_b (rst_b),
    .t     (tmr)
  );

  asw_state_t        state_ff, nxt_state;
  asw_ret_t          ret_ff, nxt_ret;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [DATA_W-1:0] wdata_ff, nxt_wdata;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic [1:0]        lanes_ff, nxt_lanes;
  logic              rsp_ff, nxt_rsp;
  logic              cs1_n_ff, nxt_cs1_n;
  logic              cs2_ff, nxt_cs2;
  logic              we_n_ff, nxt_we_n;
  logic              oe_n_ff, nxt_oe_n;
  logic              lb_n_ff, nxt_lb_n;
  logic              ub_n_ff, nxt_ub_n;
  logic              drv_ff, nxt_drv;
  logic [DATA_W-1:0] din_s1_ff;
  logic [DATA_W-1:0] din_s2_ff;

  // Pad inputs are asynchronous to mclk
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      din_s1_ff <= 16'h0000;
      din_s2_ff <= 16'h0000;
    end else begin
      din_s1_ff <= data_pins_in;
      din_s2_ff <= din_s1_ff;
    end
  end

  // Lane mask from the two active-low selects
  function automatic logic [DATA_W-1:0] lane_mask(input logic lb_n, input logic ub_n);
    return {{8{!ub_n}}, {8{!lb_n}}};
  endfunction

  always_comb begin
    nxt_state = state_ff;
    nxt_ret   = ret_ff;
    nxt_addr  = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_rdata = rdata_ff;
    nxt_lanes = lanes_ff;
    nxt_rsp   = 1'b0;
    nxt_cs1_n = cs1_n_ff;
    nxt_cs2   = cs2_ff;
    nxt_we_n  = we_n_ff;
    nxt_oe_n  = oe_n_ff;
    nxt_lb_n  = lb_n_ff;
    nxt_ub_n  = ub_n_ff;
    nxt_drv   = drv_ff;
    tmr.load  = 1'b0;
    tmr.count = 32'h0000_0000;
    unique case (state_ff)
      ASW_S_IDLE: begin
        if (req_valid && tmr.done) begin
          nxt_addr  = req_addr;
          nxt_wdata = req_wdata;
          nxt_lanes = req_lanes;
          unique case (req_op)
            ASW_OP_READ: begin
              if (req_lanes != 2'b00) begin
                // Both selects on, write strobe high, output drive low
                nxt_cs1_n = 1'b0;
                nxt_cs2   = 1'b1;
                nxt_we_n  = 1'b1;
                nxt_oe_n  = 1'b0;
                nxt_lb_n  = !req_lanes[0];
                nxt_ub_n  = !req_lanes[1];
                tmr.load  = 1'b1;
                tmr.count = 32'(RD_CYC + 2); // Extra clocks cover the input synchroniser
                nxt_state = ASW_S_RD;
              end else begin
                nxt_rsp = 1'b1;
              end
            end
            ASW_OP_WRITE: begin
              if (req_lanes != 2'b00) begin
                // Output drive high so the memory never fights our data
                nxt_cs1_n = 1'b0;
                nxt_cs2   = 1'b1;
                nxt_oe_n  = 1'b1;
                nxt_we_n  = 1'b0;
                nxt_lb_n  = !req_lanes[0];
                nxt_ub_n  = !req_lanes[1];
                tmr.load  = 1'b1;
                tmr.count = 32'(HZ_CYC); // Wait for any prior drive to float
                nxt_state = ASW_S_WR;
              end else begin
                nxt_rsp = 1'b1;
              end
            end
            ASW_OP_SLEEP: begin
              nxt_ret = req_ret;
              nxt_we_n = 1'b1;
              nxt_oe_n = 1'b1;
              unique case (req_ret)
                ASW_RET_SEC: nxt_cs2 = 1'b0;
                ASW_RET_PRI: begin
                  nxt_cs1_n = 1'b1;
                  nxt_cs2   = 1'b1;
                end
                default: begin
                  nxt_cs1_n = 1'b0;
                  nxt_cs2   = 1'b1;
                  nxt_lb_n  = 1'b1;
                  nxt_ub_n  = 1'b1;
                end
              endcase
              nxt_rsp   = 1'b1;
              nxt_state = ASW_S_SLEEP;
            end
            ASW_OP_WAKE: nxt_rsp = 1'b1; // Wake while awake is a no-op
          endcase
        end
      end
      ASW_S_RD: begin
        if (tmr.done) begin
          nxt_rdata = din_s2_ff & lane_mask(lb_n_ff, ub_n_ff);
          nxt_rsp   = 1'b1;
          nxt_cs1_n = 1'b1;
          nxt_oe_n  = 1'b1;
          nxt_lb_n  = 1'b1;
          nxt_ub_n  = 1'b1;
          tmr.load  = 1'b1;
          tmr.count = 32'(HZ_CYC);
          nxt_state = ASW_S_RD_HZ;
        end
      end
      ASW_S_RD_HZ: begin
        // Bus is held off until the memory's drive has died away
        if (tmr.done) begin
          nxt_state = ASW_S_IDLE;
        end
      end
      ASW_S_WR: begin
        if (tmr.done) begin
          nxt_drv   = 1'b1;
          tmr.load  = 1'b1;
          tmr.count = 32'(WP_CYC);
          nxt_state = ASW_S_WR_END;
        end
      end
      ASW_S_WR_END: begin
        // Data stays driven one clock past the strobe for hold
        if (tmr.done && !we_n_ff) begin
          nxt_we_n  = 1'b1;
          nxt_cs1_n = 1'b1;
          nxt_lb_n  = 1'b1;
          nxt_ub_n  = 1'b1;
        end else if (tmr.done) begin
          nxt_drv   = 1'b0;
          nxt_rsp   = 1'b1;
          nxt_state = ASW_S_IDLE;
        end
      end
      ASW_S_SLEEP: begin
        if (req_valid && req_op == ASW_OP_WAKE) begin
          nxt_cs1_n = 1'b1;
          nxt_cs2   = 1'b1;
          nxt_lb_n  = 1'b1;
          nxt_ub_n  = 1'b1;
          tmr.load  = 1'b1;
          tmr.count = 32'(RECOVER_CYC);
          nxt_state = ASW_S_WAKE;
        end else if (req_valid) begin
          nxt_rsp = 1'b1; // Other requests are answered with no access
        end
      end
      ASW_S_WAKE: begin
        if (tmr.done) begin
          nxt_rsp   = 1'b1;
          nxt_state = ASW_S_IDLE;
        end
      end
      default: nxt_state = ASW_S_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_ff <= ASW_S_IDLE;
      ret_ff   <= ASW_RET_SEC;
      addr_ff  <= 18'h0_0000;
      wdata_ff <= 16'h0000;
      rdata_ff <= 16'h0000;
      lanes_ff <= 2'b00;
      rsp_ff   <= 1'b0;
      cs1_n_ff <= 1'b1;
      cs2_ff   <= 1'b1;
      we_n_ff  <= 1'b1;
      oe_n_ff  <= 1'b1;
      lb_n_ff  <= 1'b1;
      ub_n_ff  <= 1'b1;
      drv_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ret_ff   <= nxt_ret;
      addr_ff  <= nxt_addr;
      wdata_ff <= nxt_wdata;
      rdata_ff <= nxt_rdata;
      lanes_ff <= nxt_lanes;
      rsp_ff   <= nxt_rsp;
      cs1_n_ff <= nxt_cs1_n;
      cs2_ff   <= nxt_cs2;
      we_n_ff  <= nxt_we_n;
      oe_n_ff  <= nxt_oe_n;
      lb_n_ff  <= nxt_lb_n;
      ub_n_ff  <= nxt_ub_n;
      drv_ff   <= nxt_drv;
    end
  end

  assign req_ready          = (state_ff == ASW_S_IDLE && tmr.done) || (state_ff == ASW_S_SLEEP);
  assign rsp_valid          = rsp_ff;
  assign rsp_rdata          = rdata_ff;
  assign asleep             = (state_ff == ASW_S_SLEEP) || (state_ff == ASW_S_WAKE);
  assign word_address       = addr_ff;
  assign primary_select_n   = cs1_n_ff;
  assign secondary_select   = cs2_ff;
  assign write_strobe_n     = we_n_ff;
  assign output_drive_n     = oe_n_ff;
  assign low_lane_select_n  = lb_n_ff;
  assign high_lane_select_n = ub_n_ff;
  assign data_pins_out      = wdata_ff;
  // Only the written lanes are driven
  assign data_pins_oe       = drv_ff ? lane_mask(!lanes_ff[0], !lanes_ff[1]) : 16'h0000;
endmodule // asw_ctrl

// >>> verilog/asw_pkg.sv
// Purpose: Constants and types for the host-side controller of an asynchronous 256K x 16 static memory.
// Assumes: mclk at 200 MHz (5 ns period).
// Notes: Pin timing uses the memory's 45 ns cycle figures, rounded to whole clocks.
// What this block does
// - The host puts an 18-bit word address on word_address for every access.
// - The host must not drive the data bus while the memory may still be driving read data.
// - Retention entered with the primary select must hold the secondary select at a firm level.
// - The host enters retention by secondary select low, primary select high, or both lane selects high.
// - After retention the host waits at least 5 ms before any access.
package asw_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int CLK_PERIOD_PS = 5000;
  // Access and write pulse minimums in ns
  localparam int T_RC_NS = 45;
  localparam int T_WP_NS = 35;
  localparam int T_DW_NS = 25;
  localparam int T_HZ_NS = 18;
  // Retention recovery in ms
  localparam int T_R_MS = 5;
  function automatic int ns_to_cyc_up(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int RD_CYC = ns_to_cyc_up(T_RC_NS);
  localparam int WP_CYC = ns_to_cyc_up(T_WP_NS);
  localparam int HZ_CYC = ns_to_cyc_up(T_HZ_NS);
  localparam longint RCV_CYC_L = (longint'(T_R_MS) * 1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RCV_CYC = int'(RCV_CYC_L);
  typedef enum logic [1:0] {
    ASW_OP_READ,
    ASW_OP_WRITE,
    ASW_OP_SLEEP,
    ASW_OP_WAKE
  } asw_op_t;
  typedef enum logic [1:0] {
    ASW_RET_SEC,
    ASW_RET_PRI,
    ASW_RET_LANE
  } asw_ret_t;
endpackage

// >>> verilog/asw_timer.sv
`timescale 1ns/10ps
// Purpose: Down-counter that paces pin phases of the memory controller.
// Assumes: count is at least one when loaded.
// Notes: done is high while idle and drops the cycle after load.
module asw_timer
  import asw_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Control
  asw_tmr_if.tmr   t
);
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (t.load) begin
      nxt_cnt = t.count;
    end else if (cnt_ff != 32'h0000_0000) begin
      nxt_cnt = cnt_ff - 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cnt_ff <= 32'h0000_0000;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Done must not look at load: the controller derives load from done
  assign t.done = (cnt_ff == 32'h0000_0000);
endmodule // asw_timer

// >>> verilog/asw_tmr_if.sv
`timescale 1ns/10ps
// Purpose: Carries load and done between the controller and its cycle timer.
// Assumes: Single clock domain.
// Notes: Load is a one-cycle pulse.
interface asw_tmr_if;
  logic        load;
  logic [31:0] count;
  logic        done;
  modport ctl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface
